// File: cbmu_pkg.sv
/*
 cbmu_pkg: constants, types and helpers for the block cache maintenance unit.
 Assumes a single 10 MHz system clock and a classic Wishbone register slave.
*/
package cbmu_pkg;
   localparam int unsigned LINE_SHIFT  = 6;
   localparam int unsigned LINE_W      = 32 - LINE_SHIFT;
   localparam logic [5:0]  OFF_PAIR_LAST = 6'h2C;
   localparam logic [5:0]  OFF_GLB_WB    = 6'h30;
   localparam logic [5:0]  OFF_GLB_WBINV = 6'h34;
   localparam logic [5:0]  OFF_CONFIG    = 6'h38;
   localparam logic [5:0]  OFF_STATUS    = 6'h3C;
   localparam logic [31:0] BASE_RST      = 32'h0000_0000;
   localparam logic        L2_EN_RST     = 1'b0;
   localparam logic [1:0]  PHASE_FIRST   = 2'h0;
   localparam logic [1:0]  PHASE_LAST    = 2'h2;
   localparam logic [31:0] ONCHIP_BASE   = 32'h0000_0000;
   localparam logic [31:0] ONCHIP_MASK   = 32'hFFF0_0000;

   typedef enum logic [2:0] {
      OP_L2_WB     = 3'h0,
      OP_L2_WBINV  = 3'h1,
      OP_L2_INV    = 3'h2,
      OP_L1P_INV   = 3'h3,
      OP_L1D_WBINV = 3'h4,
      OP_L1D_INV   = 3'h5,
      OP_G_WB      = 3'h6,
      OP_G_WBINV   = 3'h7
   } cbmu_op_t;

   typedef enum logic [3:0] {
      CMD_L1P_INV       = 4'h0,
      CMD_L1P_INV_ALL   = 4'h1,
      CMD_L1D_WBINV     = 4'h2,
      CMD_L1D_INV       = 4'h3,
      CMD_L1D_FLUSH_EXT = 4'h4,
      CMD_L2_WB         = 4'h5,
      CMD_L2_WBINV      = 4'h6,
      CMD_L2_INV        = 4'h7,
      CMD_L2_WB_ALL     = 4'h8,
      CMD_L2_WBINV_ALL  = 4'h9
   } cbmu_cmd_op_t;

   typedef struct packed {
      logic              valid;
      cbmu_cmd_op_t      op;
      logic [LINE_W-1:0] line;
   } cbmu_cmd_t;

   function automatic logic is_l2_op(cbmu_op_t op);
      return (op == OP_L2_WB) || (op == OP_L2_WBINV) || (op == OP_L2_INV) ||
             (op == OP_G_WB) || (op == OP_G_WBINV);
   endfunction : is_l2_op

   function automatic logic is_onchip(logic [LINE_W-1:0] line);
      return (({line, {LINE_SHIFT{1'b0}}} & ONCHIP_MASK) == ONCHIP_BASE);
   endfunction : is_onchip

   function automatic logic [31:0] lane_merge(logic [31:0] old, logic [31:0] wd,
                                              logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction : lane_merge
endpackage : cbmu_pkg

// File: cbmu_line_walker.sv
/*
 cbmu_line_walker: steps through every cache line touched by a word range.
 Assumes load and step never coincide; words is non-zero on load.
*/
module cbmu_line_walker
   import cbmu_pkg::*;
(
   input  wire logic              sys_clk_i,  // system clock
   input  wire logic              arst_n_i,   // async reset, active low
   input  wire logic              load_i,     // capture a new range
   input  wire logic [31:0]       base_i,     // start byte address
   input  wire logic [15:0]       words_i,    // word count
   input  wire logic              step_i,     // move to next line
   output logic      [LINE_W-1:0] line_o,     // current line
   output logic                   last_o,     // current line is the last
   output logic      [15:0]       remain_o    // lines left, current included
);
   logic [LINE_W-1:0] last_q;
   logic [32:0]       end_byte;

   // partial first and last lines are covered whole
   assign end_byte = {1'b0, base_i} + {15'h0, words_i, 2'b00} - 33'h1;
   assign last_o   = (line_o == last_q);
   assign remain_o = 16'(last_q - line_o + 26'h1);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         line_o <= '0;
         last_q <= '0;
      end else if (load_i) begin
         line_o <= base_i[31:LINE_SHIFT];
         last_q <= end_byte[31:LINE_SHIFT];
      end else if (step_i) begin
         line_o <= line_o + 26'h1;
      end
   end
endmodule : cbmu_line_walker

// File: cbmu_cmd_slot.sv
/*
 cbmu_cmd_slot: one-entry output register for cache commands.
 Assumes the cache side takes a command on valid and ready high together.
*/
module cbmu_cmd_slot
   import cbmu_pkg::*;
(
   input  wire logic      sys_clk_i,  // system clock
   input  wire logic      arst_n_i,   // async reset, active low
   input  cbmu_cmd_t      cmd_i,      // command to load when valid
   output logic           ready_o,    // slot can take a command
   output cbmu_cmd_t      cmd_o,      // registered command
   input  wire logic      ready_i     // cache side accepts
);
   // taking a new one while the old one leaves keeps one per cycle
   assign ready_o = !cmd_o.valid || ready_i;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_o <= '{valid: 1'b0, op: CMD_L1P_INV, line: '0};
      end else if (ready_o) begin
         cmd_o <= cmd_i;
      end
   end
endmodule : cbmu_cmd_slot

// File: cbmu_top.sv
/*
 cbmu_top: block and global cache maintenance sequencer with Wishbone registers.
 Assumes the cache arrays service the emitted commands between normal
 accesses, and that l1d_present_i is the data cache tag hit for probe_line_o.
*/
module cbmu_top
   import cbmu_pkg::*;
(
   input  wire logic              sys_clk_i,     // 10 MHz system clock
   input  wire logic              arst_n_i,      // async reset, active low
   input  wire logic              wb_cyc_i,      // bus cycle
   input  wire logic              wb_stb_i,      // strobe
   input  wire logic              wb_we_i,       // write enable
   input  wire logic [31:0]       wb_adr_i,      // byte address
   input  wire logic [3:0]        wb_sel_i,      // byte lanes
   input  wire logic [31:0]       wb_dat_i,      // write data
   output logic      [31:0]       wb_dat_o,      // read data
   output logic                   wb_ack_o,      // acknowledge
   output cbmu_cmd_t              cmd_o,         // cache command
   input  wire logic              cmd_ready_i,   // cache takes command
   output logic      [LINE_W-1:0] probe_line_o,  // line under lookup
   input  wire logic              l1d_present_i, // data cache holds probe line
   output logic                   busy_o         // operation in progress
);
   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_RUN   = 2'b01,
      ST_DRAIN = 2'b10
   } cbmu_state_t;

   cbmu_state_t       state_q;
   cbmu_op_t          op_q;
   cbmu_op_t          pair_op;
   logic [1:0]        phase_q;
   logic [31:0]       base_q;
   logic              l2_en_q;
   logic [31:0]       rd_word;
   logic [5:0]        offs;
   logic              mapped;
   logic              req;
   logic              cmd_sel;
   logic              pair_sel;
   logic              stall;
   logic              acc;
   logic              wr_acc;
   logic [15:0]       cnt_wr;
   logic              start_blk;
   logic              start_glb;
   logic              blocked;
   cbmu_op_t          start_op;
   logic              last_line;
   logic [15:0]       remain;
   logic              snoop;
   cbmu_cmd_t         plan;
   logic              slot_ready;
   logic              advance;
   logic              step;

   // bus decode
   assign offs     = wb_adr_i[5:0];
   assign mapped   = (wb_adr_i[31:6] == 26'h0);
   assign req      = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign pair_sel = mapped && (offs <= OFF_PAIR_LAST);
   assign cmd_sel  = mapped && (offs <= OFF_GLB_WBINV);
   assign pair_op  = cbmu_op_t'(offs[5:3]);
   // command writes wait; reads of the count never do, so polling works
   assign stall    = wb_we_i && cmd_sel && busy_o;
   assign acc      = req && !stall;
   assign wr_acc   = acc && wb_we_i;
   assign cnt_wr   = 16'(lane_merge(32'h0, wb_dat_i, wb_sel_i));

   always_comb begin
      start_op = pair_op;
      if (mapped && offs == OFF_GLB_WB) begin
         start_op = OP_G_WB;
      end else if (mapped && offs == OFF_GLB_WBINV) begin
         start_op = OP_G_WBINV;
      end
   end

   // all-on-chip level two: level-two commands complete at once
   assign blocked   = is_l2_op(start_op) && !l2_en_q;
   assign start_blk = wr_acc && pair_sel && offs[2] && (cnt_wr != 16'h0) && !blocked;
   assign start_glb = wr_acc && cmd_sel && !pair_sel && wb_sel_i[0] && wb_dat_i[0] && !blocked;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= acc;
      end
   end

   always_comb begin
      rd_word = 32'h0;
      if (pair_sel && offs[2]) begin
         if (busy_o && op_q != OP_G_WB && op_q != OP_G_WBINV) begin
            rd_word = {16'h0, remain};
         end
      end else if (pair_sel) begin
         rd_word = base_q;
      end else if (mapped && offs == OFF_GLB_WB) begin
         rd_word = {31'h0, busy_o && op_q == OP_G_WB};
      end else if (mapped && offs == OFF_GLB_WBINV) begin
         rd_word = {31'h0, busy_o && op_q == OP_G_WBINV};
      end else if (mapped && offs == OFF_CONFIG) begin
         rd_word = {31'h0, l2_en_q};
      end else if (mapped && offs == OFF_STATUS) begin
         rd_word = {28'h0, op_q, busy_o};
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wb_dat_o <= 32'h0;
      end else if (acc && !wb_we_i) begin
         wb_dat_o <= rd_word;
      end
   end

   // one physical base shared by every alias
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         base_q <= BASE_RST;
      end else if (wr_acc && pair_sel && !offs[2]) begin
         base_q <= lane_merge(base_q, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         l2_en_q <= L2_EN_RST;
      end else if (wr_acc && mapped && offs == OFF_CONFIG && wb_sel_i[0]) begin
         l2_en_q <= wb_dat_i[0];
      end
   end

   cbmu_line_walker u_walker (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .load_i    (start_blk || start_glb),
      .base_i    (start_blk ? base_q : 32'h0),
      .words_i   (start_blk ? cnt_wr : 16'h1),
      .step_i    (step),
      .line_o    (probe_line_o),
      .last_o    (last_line),
      .remain_o  (remain)
   );

   // inclusion means only a tag hit needs a snoop; on-chip lines never do
   assign snoop = l1d_present_i && !is_onchip(probe_line_o);

   always_comb begin
      plan = '{valid: 1'b0, op: CMD_L1P_INV, line: probe_line_o};
      unique case (op_q)
         OP_L2_WB, OP_L2_WBINV, OP_L2_INV: begin
            if (phase_q == PHASE_FIRST) begin
               plan.valid = snoop;
               plan.op    = (op_q == OP_L2_INV) ? CMD_L1D_INV : CMD_L1D_WBINV;
            end else if (phase_q != PHASE_LAST) begin
               plan.valid = (op_q != OP_L2_WB);
               plan.op    = CMD_L1P_INV;
            end else begin
               plan.valid = 1'b1;
               plan.op    = (op_q == OP_L2_WB) ? CMD_L2_WB :
                            (op_q == OP_L2_WBINV) ? CMD_L2_WBINV : CMD_L2_INV;
            end
         end
         OP_L1P_INV, OP_L1D_WBINV, OP_L1D_INV: begin
            plan.valid = (phase_q == PHASE_LAST);
            plan.op    = (op_q == OP_L1P_INV) ? CMD_L1P_INV :
                         (op_q == OP_L1D_INV) ? CMD_L1D_INV : CMD_L1D_WBINV;
         end
         OP_G_WB, OP_G_WBINV: begin
            if (phase_q == PHASE_FIRST) begin
               plan.valid = 1'b1;
               plan.op    = CMD_L1D_FLUSH_EXT;
            end else if (phase_q != PHASE_LAST) begin
               plan.valid = (op_q == OP_G_WBINV);
               plan.op    = CMD_L1P_INV_ALL;
            end else begin
               plan.valid = 1'b1;
               plan.op    = (op_q == OP_G_WB) ? CMD_L2_WB_ALL : CMD_L2_WBINV_ALL;
            end
         end
      endcase
      plan.valid = plan.valid && (state_q == ST_RUN);
   end

   // the cache interleaves these with normal traffic
   cbmu_cmd_slot u_slot (
      .sys_clk_i (sys_clk_i),
      .arst_n_i  (arst_n_i),
      .cmd_i     (plan),
      .ready_o   (slot_ready),
      .cmd_o     (cmd_o),
      .ready_i   (cmd_ready_i)
   );

   assign advance = (state_q == ST_RUN) && (!plan.valid || slot_ready);
   assign step    = advance && (phase_q == PHASE_LAST) && !last_line;

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_IDLE;
         phase_q <= PHASE_FIRST;
         op_q    <= OP_L2_WB;
         busy_o  <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start_blk || start_glb) begin
                  state_q <= ST_RUN;
                  phase_q <= PHASE_FIRST;
                  op_q    <= start_op;
                  busy_o  <= 1'b1;
               end
            end
            ST_RUN: begin
               if (advance && phase_q == PHASE_LAST) begin
                  phase_q <= PHASE_FIRST;
                  if (last_line) begin
                     state_q <= ST_DRAIN;
                  end
               end else if (advance) begin
                  phase_q <= phase_q + 2'h1;
               end
            end
            ST_DRAIN: begin
               // done only once the final command has been taken
               if (!cmd_o.valid) begin
                  state_q <= ST_IDLE;
                  busy_o  <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               busy_o  <= 1'b0;
            end
         endcase
      end
   end

   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!arst_n_i);

   logic cnt_req;
   logic base_req;
   assign cnt_req  = req && pair_sel && offs[2];
   assign base_req = req && pair_sel && !offs[2];

   a_start_runs: assert property (
      cnt_req && wb_we_i && !busy_o && cnt_wr != 16'h0 && !blocked |=> busy_o ##1 busy_o)
      else $error("non-zero count did not start an operation");
   a_zero_idle: assert property (
      cnt_req && wb_we_i && !busy_o && cnt_wr == 16'h0 |=> !busy_o [*2])
      else $error("zero count started an operation");
   a_base_stall: assert property (
      base_req && wb_we_i && busy_o |=> !wb_ack_o)
      else $error("base write acknowledged while busy");
   a_cnt_busy: assert property (
      cnt_req && !wb_we_i && busy_o && op_q != OP_G_WB && op_q != OP_G_WBINV
      |=> wb_ack_o && wb_dat_o != 32'h0)
      else $error("count read zero while running");
   a_cnt_idle: assert property (
      cnt_req && !wb_we_i && !busy_o |=> wb_ack_o && wb_dat_o == 32'h0)
      else $error("count read non-zero while idle");
   a_sram_none: assert property (
      req && wb_we_i && cmd_sel && !busy_o && is_l2_op(start_op) && !l2_en_q
      |=> !busy_o && !cmd_o.valid)
      else $error("level-two command ran with level two all on-chip");
   a_l1d_no_l1p: assert property (
      busy_o && op_q == OP_L1D_WBINV |-> !(cmd_o.valid && cmd_o.op == CMD_L1P_INV))
      else $error("data flush touched program cache");
   a_l2_l1p_inv: assert property (
      state_q == ST_RUN && (op_q == OP_L2_INV || op_q == OP_L2_WBINV) && phase_q == 2'h1
      |-> plan.valid && plan.op == CMD_L1P_INV && plan.line == probe_line_o)
      else $error("level-two invalidate skipped program cache line");
   a_glb_l1p_all: assert property (
      state_q == ST_RUN && op_q == OP_G_WBINV && phase_q == 2'h1
      |-> plan.valid && plan.op == CMD_L1P_INV_ALL)
      else $error("global writeback-invalidate skipped program cache");
   a_first_line: assert property (
      start_blk |=> probe_line_o == $past(base_q[31:LINE_SHIFT]))
      else $error("walk did not begin at the base line");
   // checked at the slot output, where the cache actually sees it
   a_glb_flush_first: assert property (
      start_glb |-> ##2 (cmd_o.valid && cmd_o.op == CMD_L1D_FLUSH_EXT))
      else $error("global operation did not flush the data cache first");
   a_onchip_quiet: assert property (
      cmd_o.valid && is_l2_op(op_q) && (cmd_o.op == CMD_L1D_INV || cmd_o.op == CMD_L1D_WBINV)
      |-> !is_onchip(cmd_o.line))
      else $error("level-two command snooped an on-chip line");
   a_wb_keeps_l1p: assert property (
      busy_o && op_q == OP_L2_WB |-> !(cmd_o.valid && cmd_o.op == CMD_L1P_INV))
      else $error("level-two writeback invalidated a program cache line");

   c_block_done: cover property (busy_o && op_q == OP_L2_WBINV ##1 !busy_o);
   c_zero_count: cover property (cnt_req && wb_we_i && !busy_o && cnt_wr == 16'h0);
   c_snoop_sent: cover property (cmd_o.valid && cmd_ready_i && cmd_o.op == CMD_L1D_INV);
   c_glb_done: cover property (busy_o && op_q == OP_G_WBINV ##1 !busy_o);
   c_stalled: cover property (base_req && wb_we_i && busy_o ##1 stall [*2]);
endmodule : cbmu_top

// File: cbmu_top_tb_top.sv
/*
 cbmu_top_tb_top: self-checking bench for the cache maintenance unit.
 Assumes one 10 MHz clock, the unit's own assertions and full-word bus accesses.
*/
module cbmu_top_tb_top
   import cbmu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              sys_clk_i = 1'b0;
   logic              arst_n_i = 1'b0;
   logic              wb_cyc_i = 1'b0;
   logic              wb_stb_i = 1'b0;
   logic              wb_we_i = 1'b0;
   logic [31:0]       wb_adr_i = 32'h0;
   logic [3:0]        wb_sel_i = 4'h0;
   logic [31:0]       wb_dat_i = 32'h0;
   logic [31:0]       wb_dat_o;
   logic              wb_ack_o;
   cbmu_cmd_t         cmd_o;
   logic              cmd_ready_i = 1'b0;
   logic [LINE_W-1:0] probe_line_o;
   logic              l1d_present_i = 1'b0;
   logic              busy_o;
   logic              hold_rdy = 1'b0;
   cbmu_cmd_t         exp_cmd[$];
   logic [32:0]       exp_rd[$];
   int                num_errors = 0;
   int                n_checks = 0;
   const cbmu_cmd_op_t op_tab[6] = '{CMD_L2_WB, CMD_L2_WBINV, CMD_L2_INV,
                                     CMD_L1P_INV, CMD_L1D_WBINV, CMD_L1D_INV};

   always #50 sys_clk_i = ~sys_clk_i;

   // random acceptance stalls the unit between commands
   always @(posedge sys_clk_i) cmd_ready_i <= hold_rdy ? 1'b0 : 1'($urandom_range(0, 1));

   cbmu_top i_dut (
      .sys_clk_i     (sys_clk_i),
      .arst_n_i      (arst_n_i),
      .wb_cyc_i      (wb_cyc_i),
      .wb_stb_i      (wb_stb_i),
      .wb_we_i       (wb_we_i),
      .wb_adr_i      (wb_adr_i),
      .wb_sel_i      (wb_sel_i),
      .wb_dat_i      (wb_dat_i),
      .wb_dat_o      (wb_dat_o),
      .wb_ack_o      (wb_ack_o),
      .cmd_o         (cmd_o),
      .cmd_ready_i   (cmd_ready_i),
      .probe_line_o  (probe_line_o),
      .l1d_present_i (l1d_present_i),
      .busy_o        (busy_o)
   );

   task automatic chk_cmd(input cbmu_cmd_t e, input cbmu_cmd_t s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD cache command expected %h seen %h", e, s);
      end
   endtask : chk_cmd

   // bit 32 set: only a non-zero value is expected
   task automatic chk_rd(input logic [32:0] e, input logic [31:0] s);
      n_checks++;
      if (e[32] ? ((|s) !== 1'b1) : (s !== e[31:0])) begin
         num_errors++;
         $display("BAD read data expected %h seen %h", e, s);
      end
   endtask : chk_rd

   task automatic chk_flag(input string n, input logic e, input logic s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD %s expected %b seen %b", n, e, s);
      end
   endtask : chk_flag

   task automatic chk_line(input logic [LINE_W-1:0] e, input logic [LINE_W-1:0] s);
      n_checks++;
      if (s !== e) begin
         num_errors++;
         $display("BAD probe line expected %h seen %h", e, s);
      end
   endtask : chk_line

   always @(posedge sys_clk_i) begin
      if (arst_n_i === 1'b1 && cmd_o.valid === 1'b1 && cmd_ready_i === 1'b1) begin
         chk_cmd(exp_cmd.size() != 0 ? exp_cmd.pop_front() : '0, cmd_o);
      end
      if (wb_cyc_i && wb_stb_i && !wb_we_i && wb_ack_o === 1'b1) begin
         chk_rd(exp_rd.size() != 0 ? exp_rd.pop_front() : 33'h0, wb_dat_o);
      end
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_sim

   initial begin
      // far above the longest expected run, still under 100k cycles
      repeat (90000) @(posedge sys_clk_i);
      num_errors++;
      end_sim();
   end

   task automatic bus(input logic we, input logic [5:0] off, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge sys_clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= {26'h0, off};
      wb_sel_i <= 4'hF;
      wb_dat_i <= d;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 3000);
      if (n >= 3000) chk_flag("bus ack", 1'b1, 1'b0);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : bus

   task automatic rd(input logic [5:0] off, input logic [32:0] e);
      exp_rd.push_back(e);
      bus(1'b0, off, 32'h0);
   endtask : rd

   task automatic push(input cbmu_cmd_op_t op, input logic [LINE_W-1:0] ln);
      exp_cmd.push_back('{1'b1, op, ln});
   endtask : push

   // writes base, notes every command the pair should emit, then writes count
   task automatic blk(input int p, input logic [31:0] b, input logic [31:0] n,
                      input logic pres, input logic l2en);
      logic [31:0]       last;
      logic [LINE_W-1:0] ln;
      last = (b + 4 * {16'h0, n[15:0]} - 1) >> LINE_SHIFT;
      l1d_present_i <= pres;
      bus(1'b1, 6'(p * 8), b);
      if (n[15:0] != 16'h0 && (p > 2 || l2en)) begin
         for (logic [31:0] k = b >> LINE_SHIFT; k <= last; k++) begin
            ln = k[LINE_W-1:0];
            if (p < 3 && pres && (({ln, 6'h0} & ONCHIP_MASK) != ONCHIP_BASE)) begin
               push(p == 2 ? CMD_L1D_INV : CMD_L1D_WBINV, ln);
            end
            if (p == 1 || p == 2) push(CMD_L1P_INV, ln);
            push(op_tab[p], ln);
         end
      end
      bus(1'b1, 6'(p * 8 + 4), n);
      // walker loaded at the edge that took the count write
      if (n[15:0] != 16'h0 && (p > 2 || l2en)) begin
         chk_line(b[31:LINE_SHIFT], probe_line_o);
      end
   endtask : blk

   task automatic wait_idle(input string name);
      int n;
      n = 0;
      while ((busy_o !== 1'b0 || exp_cmd.size() != 0) && n < 60000) begin
         @(posedge sys_clk_i);
         n++;
      end
      chk_flag("all commands seen", 1'b1, exp_cmd.size() == 0);
      chk_flag("busy", 1'b0, busy_o);
      $display("test %s done", name);
   endtask : wait_idle

   initial begin
      void'($urandom(32'h173C6ED8));
      repeat (5) @(posedge sys_clk_i);
      arst_n_i <= 1'b1;
      foreach (op_tab[i]) rd(6'(i * 8 + 4), 33'h0);
      rd(6'h00, 33'h0);
      rd(6'h38, 33'h0);
      rd(6'h3C, 33'h0);
      blk(5, 32'h1000_0000, 32'h0, 1'b1, 1'b0);
      rd(6'h2C, 33'h0);
      blk(1, 32'h1000_0000, 32'h20, 1'b1, 1'b0);
      bus(1'b1, 6'h34, 32'h1);
      wait_idle("idle cases");
      l1d_present_i <= 1'b0;
      bus(1'b1, 6'h38, 32'h1);
      rd(6'h38, 33'h1);
      hold_rdy <= 1'b1;
      blk(5, 32'h1000_0038, 32'h0001_0004, 1'b0, 1'b1);
      rd(6'h2C, 33'h1_0000_0000);
      rd(6'h18, {1'b0, 32'h1000_0038});
      fork
         begin
            repeat (20) @(posedge sys_clk_i);
            hold_rdy <= 1'b0;
         end
         bus(1'b1, 6'h00, 32'h0);
      join
      chk_flag("busy at stalled write", 1'b0, busy_o);
      wait_idle("stall and alias");
      rd(6'h2C, 33'h0);
      for (int i = 0; i < 12; i++) begin
         blk(i % 6, i < 6 ? $urandom & 32'h7FFF_FFFF : $urandom & 32'h000F_FFFF,
             $urandom_range(1, 48), 1'((i % 3) != 0), 1'b1);
         wait_idle("block op");
      end
      blk(3, 32'h2000_0100, 32'h40, 1'b0, 1'b1);
      blk(4, 32'h2000_0100, 32'h40, 1'b1, 1'b1);
      wait_idle("code handoff");
      rd(6'h1C, 33'h0);
      rd(6'h24, 33'h0);
      hold_rdy <= 1'b1;
      push(CMD_L1D_FLUSH_EXT, '0);
      push(CMD_L1P_INV_ALL, '0);
      push(CMD_L2_WBINV_ALL, '0);
      bus(1'b1, 6'h34, 32'h1);
      rd(6'h34, 33'h1);
      hold_rdy <= 1'b0;
      wait_idle("global wbinv");
      push(CMD_L1D_FLUSH_EXT, '0);
      push(CMD_L2_WB_ALL, '0);
      bus(1'b1, 6'h30, 32'h1);
      wait_idle("global wb");
      blk(5, 32'h0, 32'hFFFF_FFFF, 1'b0, 1'b1);
      wait_idle("max count");
      end_sim();
   end
endmodule : cbmu_top_tb_top
